// ===== logic/cfs_pkg.sv
package cfs_pkg;
   localparam int unsigned ADDR_W         = 13;
   localparam int unsigned DATA_W         = 32;
   localparam int unsigned COUNT_W        = 16;
   localparam int unsigned COORD_W        = 11;
   localparam logic [12:0] OFS_FRAME_RATE = 13'h0600;
   localparam logic [12:0] OFS_STREAM     = 13'h0614;
   localparam logic [12:0] OFS_SHOT       = 13'h061c;
   localparam logic [12:0] OFS_WIDE_ORDER = 13'h1048;
   localparam logic [31:0] RATE_RESET     = 32'h6000_0000;
   localparam logic [31:0] STREAM_RESET   = 32'h0000_0000;
   localparam logic [31:0] SHOT_RESET     = 32'h0000_0000;
   localparam logic [31:0] ORDER_RESET    = 32'h0000_0000;
   localparam logic [31:0] STREAM_ON      = 32'h8000_0000;
   localparam logic [31:0] STREAM_OFF     = 32'h0000_0000;
   localparam logic [31:0] RATE_30_VALUE  = 32'h8000_0000;
   localparam int unsigned STREAM_BIT     = 31;
   localparam int unsigned SHOT_ONE_BIT   = 31;
   localparam int unsigned SHOT_MULTI_BIT = 30;
   localparam int unsigned ORDER_SWAP_BIT = 0;
   localparam int unsigned RATE_LSB       = 29;
   localparam logic [2:0]  RATE_1P875     = 3'h0;
   localparam logic [2:0]  RATE_3P75      = 3'h1;
   localparam logic [2:0]  RATE_7P5       = 3'h2;
   localparam logic [2:0]  RATE_15        = 3'h3;
   localparam logic [2:0]  RATE_30        = 3'h4;
   localparam logic [2:0]  FMT_LOW        = 3'h0;
   localparam logic [2:0]  FMT_HIGH       = 3'h1;
   localparam logic [2:0]  FMT_CUSTOM     = 3'h7;
   localparam logic [2:0]  MODE_NARROW    = 3'h5;
   localparam logic [2:0]  MODE_WIDE_LOW  = 3'h6;
   localparam logic [2:0]  MODE_WIDE_HIGH = 3'h7;
   localparam logic [2:0]  MODE_WINDOW    = 3'h0;
   localparam logic [2:0]  MODE_SUBSAMPLE = 3'h1;

   typedef enum logic [1:0] {CFS_WAIT, CFS_STREAM, CFS_SHOT} cfs_state_type;

   typedef struct packed {
      cfs_state_type        state;
      logic [31:0]          frame_rate;
      logic                 stream;
      logic [31:0]          shot;
      logic                 swap;
      logic [COUNT_W-1:0]   left;
      logic                 frame_on;
      logic                 pend;
      logic [7:0]           pend_byte;
      logic                 byte_valid;
      logic [7:0]           byte_data;
      logic                 sof;
      logic                 eof;
      logic                 rvalid;
      logic [31:0]          rdata;
   } cfs_regs_type;
endpackage

// ===== logic/cfs_shot_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Only listed format, mode and rate combinations are transmitted.
// - Custom mode 0 sends only the host-chosen rectangle, sensor rate kept.
// - Custom mode 1 on low-res part sends every other line, 640x240.
// - Custom mode 1 on high-res part sends every other line, 1024x384.
// - Narrow pixels one byte; wide pixels high then low, order switchable.
// - Frame-rate register writable live; top bit alone means 30 Hz.
// - Writing zero to stream enable stops continuous transmission.
// - Writing top bit alone to stream enable resumes continuous transmission.
// - Shot top bit with streaming off captures exactly one image.
// - Shot second bit captures the count given in the low field.
// - After requested images, return to waiting, send nothing more.
module cfs_shot_ctrl
(
   input  wire logic                         ref_clk,
   input  wire logic                         arst_n,
   input  wire logic                         clk_en,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   input  wire logic [cfs_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [31:0]                  reg_wdata,
   output logic      [31:0]                  reg_rdata,
   output logic                              reg_rvalid,
   input  wire logic                         sensor_hires,
   input  wire logic [2:0]                   video_format,
   input  wire logic [2:0]                   video_mode,
   input  wire logic                         custom_wide,
   input  wire logic [cfs_pkg::COORD_W-1:0]  win_x0,
   input  wire logic [cfs_pkg::COORD_W-1:0]  win_x1,
   input  wire logic [cfs_pkg::COORD_W-1:0]  win_y0,
   input  wire logic [cfs_pkg::COORD_W-1:0]  win_y1,
   output logic      [2:0]                   rate_code,
   output logic                              subsample,
   output logic                              mode_ok,
   input  wire logic                         frame_start,
   input  wire logic                         frame_end,
   input  wire logic                         pix_valid,
   output logic                              pix_ready,
   input  wire logic [15:0]                  pix_data,
   input  wire logic [cfs_pkg::COORD_W-1:0]  pix_x,
   input  wire logic [cfs_pkg::COORD_W-1:0]  pix_y,
   output logic                              byte_valid,
   output logic      [7:0]                   byte_data,
   output logic                              tx_frame_start,
   output logic                              tx_frame_end
);
   cfs_pkg::cfs_regs_type r_r;
   cfs_pkg::cfs_regs_type r_nxt;
   logic                  wide;
   logic                  in_win;
   logic                  take;
   logic                  wr_rate;
   logic                  wr_stream;
   logic                  wr_shot;
   logic                  last_shot;
   logic                  start_ok;

   function automatic logic combo_ok(input logic hi, input logic [2:0] f, input logic [2:0] m,
                                     input logic [2:0] rc);
      logic ok;
      ok = 1'b0;
      case (f)
         cfs_pkg::FMT_LOW:
            ok = !hi && (m == cfs_pkg::MODE_NARROW || m == cfs_pkg::MODE_WIDE_LOW)
                 && rc >= cfs_pkg::RATE_3P75 && rc <= cfs_pkg::RATE_30;
         cfs_pkg::FMT_HIGH:
            ok = hi && ((m == cfs_pkg::MODE_NARROW && rc <= cfs_pkg::RATE_15)
                 || (m == cfs_pkg::MODE_WIDE_HIGH && rc <= cfs_pkg::RATE_7P5));
         cfs_pkg::FMT_CUSTOM:
            ok = (m == cfs_pkg::MODE_WINDOW || m == cfs_pkg::MODE_SUBSAMPLE);
         default:
            ok = 1'b0;
      endcase
      return ok;
   endfunction

   assign rate_code = r_r.frame_rate[31:cfs_pkg::RATE_LSB];
   assign mode_ok   = combo_ok(sensor_hires, video_format, video_mode, rate_code);
   assign subsample = video_format == cfs_pkg::FMT_CUSTOM && video_mode == cfs_pkg::MODE_SUBSAMPLE;
   assign wide      = (video_format == cfs_pkg::FMT_LOW && video_mode == cfs_pkg::MODE_WIDE_LOW)
                   || (video_format == cfs_pkg::FMT_HIGH && video_mode == cfs_pkg::MODE_WIDE_HIGH)
                   || (video_format == cfs_pkg::FMT_CUSTOM && custom_wide);
   assign in_win    = !(video_format == cfs_pkg::FMT_CUSTOM && video_mode == cfs_pkg::MODE_WINDOW)
                   || (pix_x >= win_x0 && pix_x <= win_x1 && pix_y >= win_y0 && pix_y <= win_y1);
   assign pix_ready = !r_r.pend;
   assign take      = pix_valid && pix_ready && r_r.frame_on && in_win && !(subsample && pix_y[0]);
   assign wr_rate   = reg_wr && reg_addr == cfs_pkg::OFS_FRAME_RATE;
   assign wr_stream = reg_wr && reg_addr == cfs_pkg::OFS_STREAM;
   assign wr_shot   = reg_wr && reg_addr == cfs_pkg::OFS_SHOT;
   assign last_shot = r_r.state == cfs_pkg::CFS_SHOT && r_r.frame_on && frame_end
                   && r_r.left == 16'h0001;
   assign start_ok  = mode_ok && (r_r.state == cfs_pkg::CFS_SHOT
                   || (r_r.state == cfs_pkg::CFS_STREAM && r_r.stream));

   assign reg_rdata      = r_r.rdata;
   assign reg_rvalid     = r_r.rvalid;
   assign byte_valid     = r_r.byte_valid;
   assign byte_data      = r_r.byte_data;
   assign tx_frame_start = r_r.sof;
   assign tx_frame_end   = r_r.eof;

   always_comb
   begin
      r_nxt            = r_r;
      r_nxt.byte_valid = 1'b0;
      r_nxt.sof        = 1'b0;
      r_nxt.eof        = 1'b0;
      r_nxt.rvalid     = reg_rd;
      case (reg_addr)
         cfs_pkg::OFS_FRAME_RATE: r_nxt.rdata = r_r.frame_rate;
         cfs_pkg::OFS_STREAM:     r_nxt.rdata = {r_r.stream, 31'h0};
         cfs_pkg::OFS_SHOT:       r_nxt.rdata = r_r.shot;
         cfs_pkg::OFS_WIDE_ORDER: r_nxt.rdata = {31'h0, r_r.swap};
         default:                 r_nxt.rdata = 32'h0;
      endcase
      if (wr_rate)
         r_nxt.frame_rate = reg_wdata;
      if (reg_wr && reg_addr == cfs_pkg::OFS_WIDE_ORDER)
         r_nxt.swap = reg_wdata[cfs_pkg::ORDER_SWAP_BIT];
      if (wr_stream)
         r_nxt.stream = reg_wdata[cfs_pkg::STREAM_BIT];
      // Frame gating at frame boundaries
      if (frame_start && !r_r.frame_on)
      begin
         r_nxt.frame_on = start_ok;
         r_nxt.sof      = start_ok;
      end
      if (frame_end && r_r.frame_on)
      begin
         r_nxt.frame_on = 1'b0;
         r_nxt.eof      = 1'b1;
      end
      case (r_r.state)
         cfs_pkg::CFS_WAIT:
         begin
            if (r_r.stream)
               r_nxt.state = cfs_pkg::CFS_STREAM;
         end
         cfs_pkg::CFS_STREAM:
         begin
            if (!r_r.stream && !r_r.frame_on)
               r_nxt.state = cfs_pkg::CFS_WAIT;
         end
         cfs_pkg::CFS_SHOT:
         begin
            if (r_r.frame_on && frame_end)
               r_nxt.left = r_r.left - 16'h0001;
            if (last_shot)
            begin
               r_nxt.state = cfs_pkg::CFS_WAIT;
               r_nxt.shot  = {2'b00, r_r.shot[29:0]};
            end
         end
         default:
            r_nxt.state = cfs_pkg::CFS_WAIT;
      endcase
      if (wr_shot && !r_r.stream && r_r.state == cfs_pkg::CFS_WAIT)
      begin
         r_nxt.shot = reg_wdata;
         if (reg_wdata[cfs_pkg::SHOT_ONE_BIT])
            r_nxt.left = 16'h0001;
         else
            r_nxt.left = reg_wdata[cfs_pkg::COUNT_W-1:0];
         if (reg_wdata[cfs_pkg::SHOT_ONE_BIT] || (reg_wdata[cfs_pkg::SHOT_MULTI_BIT]
             && reg_wdata[cfs_pkg::COUNT_W-1:0] != 16'h0000))
            r_nxt.state = cfs_pkg::CFS_SHOT;
         else
            r_nxt.shot = {2'b00, reg_wdata[29:0]};
      end
      if (r_r.pend)
      begin
         r_nxt.byte_valid = 1'b1;
         r_nxt.byte_data  = r_r.pend_byte;
         r_nxt.pend       = 1'b0;
      end
      else if (take)
      begin
         r_nxt.byte_valid = 1'b1;
         if (!wide)
            r_nxt.byte_data = pix_data[7:0];
         else
         begin
            r_nxt.pend      = 1'b1;
            r_nxt.byte_data = r_r.swap ? pix_data[7:0] : pix_data[15:8];
            r_nxt.pend_byte = r_r.swap ? pix_data[15:8] : pix_data[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r_r            <= '0;
         r_r.state      <= cfs_pkg::CFS_WAIT;
         r_r.frame_rate <= cfs_pkg::RATE_RESET;
         r_r.stream     <= cfs_pkg::STREAM_RESET[cfs_pkg::STREAM_BIT];
         r_r.shot       <= cfs_pkg::SHOT_RESET;
         r_r.swap       <= cfs_pkg::ORDER_RESET[cfs_pkg::ORDER_SWAP_BIT];
      end
      else if (clk_en)
         r_r <= r_nxt;
   end

   a_rate_thirty: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && wr_rate && reg_wdata == cfs_pkg::RATE_30_VALUE |=> rate_code == cfs_pkg::RATE_30)
      else $error("rate value not 30 Hz");
   a_stream_stop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && wr_stream && reg_wdata == cfs_pkg::STREAM_OFF |=> !r_r.stream)
      else $error("stream not stopped");
   a_stream_go: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && wr_stream && reg_wdata == cfs_pkg::STREAM_ON |=> r_r.stream)
      else $error("stream not resumed");
   a_single_shot: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && wr_shot && reg_wdata == 32'h8000_0000 && !r_r.stream
      && r_r.state == cfs_pkg::CFS_WAIT |=> r_r.state == cfs_pkg::CFS_SHOT && r_r.left == 16'h0001)
      else $error("single shot not armed");
   a_multi_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && wr_shot && reg_wdata == 32'h4000_00af && !r_r.stream
      && r_r.state == cfs_pkg::CFS_WAIT |=> r_r.left == 16'h00af)
      else $error("multi shot count wrong");
   a_shot_done: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && last_shot && !wr_shot |=> r_r.state == cfs_pkg::CFS_WAIT ##1 !r_r.frame_on)
      else $error("images after shot end");
   a_shot_clear: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && last_shot |=> r_r.shot[31:30] == 2'b00)
      else $error("shot bits not cleared");
   a_wide_pair: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && take && wide |=> byte_valid && r_r.pend && !pix_ready
      && byte_data == ($past(r_r.swap) ? $past(pix_data[7:0]) : $past(pix_data[15:8])))
      else $error("wide pixel byte order wrong");
   a_mode_block: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && frame_start && !r_r.frame_on && !mode_ok |=> !r_r.frame_on && !tx_frame_start)
      else $error("unsupported mode transmitted");
   a_window_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && pix_valid && pix_ready && !in_win |=> !byte_valid)
      else $error("pixel outside window sent");
   a_sub_rows: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && subsample && pix_y[0] && !r_r.pend |=> !byte_valid)
      else $error("odd line sent in subsample");

   c_single_done: cover property (@(posedge ref_clk) disable iff (!arst_n)
      r_r.state == cfs_pkg::CFS_SHOT ##[1:200] r_r.state == cfs_pkg::CFS_WAIT);
   c_wide_bytes: cover property (@(posedge ref_clk) disable iff (!arst_n)
      byte_valid && r_r.pend ##1 byte_valid);
   c_stream_run: cover property (@(posedge ref_clk) disable iff (!arst_n)
      r_r.state == cfs_pkg::CFS_STREAM && tx_frame_end);
endmodule

// ===== test/cfs_sensor_model.sv
`timescale 1ns/1ps
module cfs_sensor_model
(
   input  wire logic        ref_clk,
   input  wire logic        go,
   input  wire logic        pix_ready,
   output logic             busy,
   output logic             frame_start,
   output logic             frame_end,
   output logic             pix_valid,
   output logic [15:0]      pix_data,
   output logic [10:0]      pix_x,
   output logic [10:0]      pix_y
);
   logic acc;
   initial
   begin
      {busy, frame_start, frame_end, pix_valid, pix_data, pix_x, pix_y, acc} = '0;
   end
   // Take seen at the edge itself
   always @(posedge ref_clk) acc <= pix_valid & pix_ready;
   // Frame of two lines, two pixels each, each held until taken
   always @(posedge go)
   begin
      busy = 1'b1;
      @(negedge ref_clk) frame_start = 1'b1;
      @(negedge ref_clk) frame_start = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         pix_valid = 1'b1;
         pix_x = 11'(i % 2);
         pix_y = 11'(i / 2);
         pix_data = {4'ha, 4'(i / 2), 4'(i / 2), 4'(i % 2)};
         @(negedge ref_clk);
         while (acc !== 1'b1) @(negedge ref_clk);
      end
      pix_valid = 1'b0;
      pix_data = ~pix_data;
      frame_end = 1'b1;
      @(negedge ref_clk) frame_end = 1'b0;
      busy = 1'b0;
   end
endmodule

// ===== test/test_camera_format_and_shot_control.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module test_camera_format_and_shot_control;
   logic ref_clk, arst_n, clk_en, reg_wr, reg_rd, reg_rvalid, sensor_hires, custom_wide;
   logic [12:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0]  video_format, video_mode, rate_code;
   logic [10:0] win_x0, win_x1, win_y0, win_y1, pix_x, pix_y;
   logic        subsample, mode_ok, frame_start, frame_end, pix_valid, pix_ready, go, busy;
   logic [15:0] pix_data;
   logic        byte_valid, tx_frame_start, tx_frame_end;
   logic [7:0]  byte_data;
   logic [7:0]  got[$];
   int          errors, cmp_count, nsof;
   cfs_shot_ctrl dut (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .sensor_hires(sensor_hires), .video_format(video_format),
      .video_mode(video_mode), .custom_wide(custom_wide), .win_x0(win_x0), .win_x1(win_x1),
      .win_y0(win_y0), .win_y1(win_y1), .rate_code(rate_code), .subsample(subsample),
      .mode_ok(mode_ok), .frame_start(frame_start), .frame_end(frame_end),
      .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data), .pix_x(pix_x),
      .pix_y(pix_y), .byte_valid(byte_valid), .byte_data(byte_data),
      .tx_frame_start(tx_frame_start), .tx_frame_end(tx_frame_end));
   cfs_sensor_model sensor (.ref_clk(ref_clk), .go(go), .pix_ready(pix_ready), .busy(busy),
      .frame_start(frame_start), .frame_end(frame_end), .pix_valid(pix_valid),
      .pix_data(pix_data), .pix_x(pix_x), .pix_y(pix_y));
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (byte_valid === 1'b1) got.push_back(byte_data);
      if (tx_frame_start === 1'b1) nsof++;
   end
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdc(input logic [12:0] a, input logic [31:0] e, input logic [31:0] m);
      @(negedge ref_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      `CHK("rvalid", 1'b1, reg_rvalid)
      `CHK("rdata", e, reg_rdata & m)
   endtask
   task automatic frame(input int n);
      got.delete();
      nsof = 0;
      @(negedge ref_clk) go = 1'b1;
      @(negedge ref_clk) go = 1'b0;
      repeat (40) if (busy === 1'b1) @(negedge ref_clk);
      `CHK("idle", 1'b0, busy)
      repeat (4) @(negedge ref_clk);
      `CHK("bytes", n, got.size())
      `CHK("frames", int'(n > 0), nsof)
   endtask
   task automatic mck(input logic h, input logic [2:0] f, input logic [2:0] m, input logic e);
      @(negedge ref_clk);
      sensor_hires = h;
      video_format = f;
      video_mode = m;
      #1 `CHK("mode_ok", e, mode_ok)
   endtask
   task automatic t_reset();
      rdc(cfs_pkg::OFS_FRAME_RATE, 32'h6000_0000, '1);
      rdc(cfs_pkg::OFS_STREAM, 32'h0000_0000, '1);
      rdc(cfs_pkg::OFS_SHOT, 32'h0000_0000, '1);
      rdc(cfs_pkg::OFS_WIDE_ORDER, 32'h0000_0000, '1);
      rdc(13'h0004, 32'h0000_0000, '1);
      clk_en = 1'b0;
      wr(cfs_pkg::OFS_FRAME_RATE, 32'h0000_0000);
      clk_en = 1'b1;
      rdc(cfs_pkg::OFS_FRAME_RATE, 32'h6000_0000, '1);
      `CHK("rate_code", 3'h3, rate_code)
      $display("test reset done");
   endtask
   task automatic t_rate();
      wr(cfs_pkg::OFS_FRAME_RATE, 32'h8000_0000);
      rdc(cfs_pkg::OFS_FRAME_RATE, 32'h8000_0000, '1);
      `CHK("rate_code", 3'h4, rate_code)
      mck(1'b0, 3'h0, 3'h5, 1'b1);
      mck(1'b0, 3'h0, 3'h6, 1'b1);
      mck(1'b1, 3'h1, 3'h5, 1'b0);
      mck(1'b1, 3'h1, 3'h7, 1'b0);
      wr(cfs_pkg::OFS_FRAME_RATE, 32'h0000_0000);
      mck(1'b1, 3'h1, 3'h5, 1'b1);
      mck(1'b1, 3'h1, 3'h7, 1'b1);
      mck(1'b0, 3'h0, 3'h5, 1'b0);
      wr(cfs_pkg::OFS_FRAME_RATE, 32'h8000_0000);
      mck(1'b0, 3'h0, 3'h5, 1'b1);
      $display("test rate done");
   endtask
   task automatic t_stream();
      wr(cfs_pkg::OFS_STREAM, 32'h8000_0000);
      rdc(cfs_pkg::OFS_STREAM, 32'h8000_0000, '1);
      frame(4);
      video_mode = 3'h6;
      frame(8);
      `CHK("hi", 8'ha0, got[0])
      `CHK("lo", 8'h00, got[1])
      wr(cfs_pkg::OFS_WIDE_ORDER, 32'h0000_0001);
      rdc(cfs_pkg::OFS_WIDE_ORDER, 32'h0000_0001, '1);
      frame(8);
      `CHK("lo", 8'h11, got[6])
      `CHK("hi", 8'ha1, got[7])
      wr(cfs_pkg::OFS_WIDE_ORDER, 32'h0000_0000);
      video_format = 3'h7;
      video_mode = 3'h0;
      win_x0 = 11'h001;
      win_x1 = 11'h001;
      frame(2);
      `CHK("win first", 8'h01, got[0])
      `CHK("win second", 8'h11, got[1])
      win_x0 = 11'h000;
      win_x1 = 11'h7ff;
      video_mode = 3'h1;
      #1 `CHK("subsample", 1'b1, subsample)
      frame(2);
      `CHK("line", 8'h01, got[1])
      sensor_hires = 1'b1;
      custom_wide = 1'b1;
      frame(4);
      `CHK("wide line", 8'h01, got[3])
      $display("test stream done");
   endtask
   task automatic t_shot();
      sensor_hires = 1'b0;
      custom_wide = 1'b0;
      video_format = 3'h0;
      video_mode = 3'h5;
      wr(cfs_pkg::OFS_STREAM, 32'h0000_0000);
      frame(0);
      wr(cfs_pkg::OFS_SHOT, 32'h8000_0000);
      frame(4);
      rdc(cfs_pkg::OFS_SHOT, 32'h0000_0000, 32'hc000_0000);
      frame(0);
      wr(cfs_pkg::OFS_SHOT, 32'h4000_0002);
      frame(4);
      frame(4);
      rdc(cfs_pkg::OFS_SHOT, 32'h0000_0000, 32'hc000_0000);
      frame(0);
      $display("test shot done");
   endtask
   initial
   begin
      {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, sensor_hires, custom_wide, go} = '0;
      {video_format, win_x0, win_y0} = '0;
      video_mode = 3'h5;
      clk_en = 1'b1;
      win_x1 = 11'h7ff;
      win_y1 = 11'h7ff;
      repeat (6) @(negedge ref_clk);
      arst_n = 1'b1;
      t_reset();
      t_rate();
      t_stream();
      t_shot();
      end_of_test();
   end
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      errors++;
      end_of_test();
   end
endmodule
